// *** bench/bcf_host.sv ***
// host initiator model: single data phase reads and writes
// assumes the target answers on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "bcf_map.svh"
module bcf_host (
  input  wire logic        clock,
  input  wire logic [31:0] ad_out,
  input  wire logic        ad_oe,
  input  wire logic        trdy_n,
  output logic             frame_n,
  output logic             irdy_n,
  output logic      [31:0] ad_in,
  output logic      [3:0]  cbe_n
);
  logic        h_oe;
  logic [31:0] h_ad;
  // floating bus shows the inverse of the last host value, never a hold
  assign ad_in = h_oe ? h_ad : (ad_oe ? ad_out : ~h_ad);
  initial begin
    frame_n = 1'b1;
    irdy_n  = 1'b1;
    h_oe    = 1'b0;
    h_ad    = 32'h0000_0000;
    cbe_n   = 4'hf;
  end
  task automatic xfer(input logic wr, input logic [31:0] addr,
                      input logic [15:0] wd, input logic [1:0] be,
                      output logic [31:0] rd, output logic ok);
    int n;
    repeat (2) @(posedge clock);
    #1;
    frame_n = 1'b0;
    h_oe    = 1'b1;
    h_ad    = addr;
    cbe_n   = wr ? ~`BCF_CMD_MEM_WR : ~`BCF_CMD_MEM_RD;
    @(posedge clock);
    #1;
    frame_n = 1'b1;
    irdy_n  = 1'b0;
    h_oe    = wr;
    h_ad    = {16'h0000, wd};
    cbe_n   = {2'b11, ~be};
    n       = 0;
    ok      = 1'b0;
    // unclaimed access is given up after a few edges
    while (!ok && n < 6) begin
      @(posedge clock);
      ok = (trdy_n === 1'b0);
      n++;
    end
    rd = ad_in;
    #1;
    irdy_n = 1'b1;
    h_oe   = 1'b0;
    cbe_n  = 4'hf;
  endtask
endmodule
`default_nettype wire

// *** bench/bcf_regs_asserts.sv ***
// port checker for the condition/flag register bank
// assumes a bind onto every bcf_regs instance, one clock domain
`timescale 1ns/10ps
`default_nettype none
`include "bcf_map.svh"
module bcf_regs_asserts (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        frame_n,
  input wire logic        irdy_n,
  input wire logic [31:0] ad_in,
  input wire logic [3:0]  cbe_n,
  input wire logic [31:0] ad_out,
  input wire logic        ad_oe,
  input wire logic        par_out,
  input wire logic        par_oe,
  input wire logic        devsel_n,
  input wire logic        trdy_n,
  input wire logic        devsel_oe,
  input wire logic        trdy_oe,
  input wire logic        stop_n,
  input wire logic        stop_oe,
  input wire logic        seq_online,
  input wire logic [7:0]  seq_cond_hi,
  input wire logic        cmp_valid,
  input wire logic        cmp_less,
  input wire logic        cmp_equal,
  input wire logic [7:0]  gp_flags,
  input wire logic [5:0]  mm_base,
  input wire logic        rt_halt_en,
  input wire logic        resp_time_sel,
  input wire logic        timetag_sync,
  input wire logic        watchdog_en,
  input wire logic        message_in_progress_output
);
  logic [6:0]  ofs;
  logic        wr;
  logic        dp;
  logic        wf;
  logic [7:0]  se;
  logic [7:0]  cl;
  logic [15:0] cfg;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ***************
  // access tracking
  // ***************
  // offset kept past the address phase so data edges can be decoded
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ofs <= 7'h00;
      wr  <= 1'b0;
    end else if (!frame_n && devsel_n) begin
      ofs <= ad_in[6:0];
      wr  <= (cbe_n == ~`BCF_CMD_MEM_WR);
    end
  end
  assign dp  = !irdy_n && !trdy_n;
  assign wf  = dp && wr && (ofs == `BCF_OFS_FLAG_COND);
  assign se  = ad_in[7:0] & {8{!cbe_n[0]}};
  assign cl  = ad_in[15:8] & {8{!cbe_n[1]}};
  assign cfg = {mm_base, 5'h00, rt_halt_en, resp_time_sel, timetag_sync,
                watchdog_en, message_in_progress_output};
  a_flag_set_clear: assert property (wf && !cmp_valid |=>
    gp_flags == (($past(gp_flags) & ~$past(cl)) | $past(se)))
    else $error("flag port write gave wrong flags");
  a_flag_hold: assert property (!wf && !cmp_valid |=>
    $stable(gp_flags)) else $error("flags changed without cause");
  a_cmp_load: assert property (cmp_valid |=>
    gp_flags[1:0] == {$past(cmp_less), $past(cmp_equal)})
    else $error("compare result not loaded");
  a_cond_online: assert property ($rose(ad_oe) && $past(seq_online)
    && ofs == `BCF_OFS_FLAG_COND |->
    ad_out == {16'h0000, $past(seq_cond_hi), $past(gp_flags)})
    else $error("condition word wrong");
  a_cond_offline: assert property ($rose(ad_oe) && !$past(seq_online)
    && ofs == `BCF_OFS_FLAG_COND |-> ad_out == `BCF_WORD_ZERO)
    else $error("offline condition word not zero");
  a_bist_zeros: assert property ($rose(ad_oe)
    && ofs == `BCF_OFS_SELF_TEST |->
    ad_out[31:8] == 24'h00_0000 && ad_out[4:0] == 5'h00)
    else $error("self-test word unused bits set");
  a_cfg_write: assert property (dp && wr && cbe_n[1:0] == 2'b00
    && ofs == `BCF_OFS_CONFIG_SEVEN |=>
    cfg == ($past(ad_in[15:0]) & `BCF_CFG_WMASK))
    else $error("config write wrong");
  a_cfg_read: assert property ($rose(ad_oe)
    && ofs == `BCF_OFS_CONFIG_SEVEN |-> ad_out == {16'h0000, cfg})
    else $error("config read wrong");
  a_read_parity: assert property (par_oe && $past(ad_oe) |->
    par_out == ^{$past(ad_out), $past(cbe_n)})
    else $error("read parity wrong");
  a_strobe_pair: assert property (devsel_n == trdy_n && stop_n == trdy_n
    && devsel_oe == trdy_oe && stop_oe == trdy_oe && (trdy_oe || trdy_n))
    else $error("target strobes out of step");
  a_turn_release: assert property (!trdy_n && !irdy_n |=>
    trdy_n && trdy_oe ##1 !trdy_oe)
    else $error("turnaround not released");
endmodule
bind bcf_regs bcf_regs_asserts bcf_regs_asserts_i (.clock, .rst_n,
  .frame_n, .irdy_n, .ad_in, .cbe_n, .ad_out, .ad_oe, .par_out, .par_oe,
  .devsel_n, .trdy_n, .devsel_oe, .trdy_oe, .stop_n, .stop_oe,
  .seq_online, .seq_cond_hi, .cmp_valid, .cmp_less,
  .cmp_equal, .gp_flags, .mm_base, .rt_halt_en, .resp_time_sel,
  .timetag_sync, .watchdog_en, .message_in_progress_output);
`default_nettype wire

// *** bench/tb_bcf_regs.sv ***
// self-checking bench for the condition/flag register bank
// assumes bcf_host drives the bus; sequencer side driven here
`timescale 1ns/10ps
`default_nettype none
module tb_bcf_regs;
  localparam logic [31:0] BASE = 32'h8000_0000;
  typedef struct packed {
    logic [6:0]  ofs;
    logic [15:0] wd;
    logic [1:0]  be;
    logic [15:0] exp;
  } bcf_row_t;
  logic        clock, rst_n, frame_n, irdy_n, ad_oe, par_out, par_oe;
  logic        devsel_n, devsel_oe, trdy_n, trdy_oe, stop_n, stop_oe;
  logic        seq_online, cmp_valid, cmp_less, cmp_equal, ok;
  logic        bist_start, bist_done, bist_pass, rt_halt_en;
  logic        resp_time_sel, timetag_sync, watchdog_en;
  logic        message_in_progress_output;
  logic [31:0] ad_in, ad_out, rd;
  logic [7:0]  seq_cond_hi, gp_flags;
  logic [5:0]  mm_base;
  logic [3:0]  cbe_n;
  int          error_cnt, comparisons, i;
  bcf_row_t    rows [10] = '{
    '{7'h64, 16'hffff, 2'b11, 16'hfc1f}, '{7'h64, 16'h0412, 2'b11, 16'h0412},
    '{7'h64, 16'hffff, 2'b01, 16'h041f}, '{7'h6c, 16'h00ff, 2'b11, 16'ha5ff},
    '{7'h6c, 16'h0f00, 2'b11, 16'ha5f0}, '{7'h6c, 16'h8080, 2'b11, 16'ha5f0},
    '{7'h6c, 16'hff00, 2'b01, 16'ha5f0}, '{7'h6c, 16'hf000, 2'b10, 16'ha500},
    '{7'h70, 16'hffff, 2'b11, 16'h0000}, '{7'h40, 16'hffff, 2'b11, 16'h0000}};
  bcf_regs #(.BASE_ADDR(BASE)) bcf_regs_i (.clock, .rst_n, .frame_n,
    .irdy_n, .ad_in, .cbe_n, .ad_out, .ad_oe, .par_out, .par_oe, .devsel_n,
    .devsel_oe, .trdy_n, .trdy_oe, .stop_n, .stop_oe, .seq_online,
    .seq_cond_hi, .cmp_valid, .cmp_less, .cmp_equal, .gp_flags, .bist_start,
    .bist_done, .bist_pass, .mm_base, .rt_halt_en, .resp_time_sel,
    .timetag_sync, .watchdog_en, .message_in_progress_output);
  bcf_host bcf_host_i (.clock, .ad_out, .ad_oe, .trdy_n, .frame_n, .irdy_n,
    .ad_in, .cbe_n);
  initial clock = 1'b0;
  always #10 clock = ~clock;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic rdx(input logic [6:0] ofs);
    bcf_host_i.xfer(1'b0, {BASE[31:7], ofs}, 16'h0000, 2'b11, rd, ok);
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // *******
  // watchdog
  // *******
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    {rst_n, seq_online, cmp_valid, cmp_less, cmp_equal} = 5'h00;
    {bist_start, bist_done, bist_pass} = 3'h0;
    seq_cond_hi = 8'ha5;
    repeat (10) step();
    chk({14'h0000, gp_flags, devsel_n, trdy_n, stop_n, ad_oe, mm_base},
        32'h0000_0380);
    rst_n = 1'b1;
    seq_online = 1'b1;
    for (i = 0; i < 10; i++) begin
      bcf_host_i.xfer(1'b1, {BASE[31:7], rows[i].ofs}, rows[i].wd,
                      rows[i].be, rd, ok);
      rdx(rows[i].ofs);
      chk(rd, {16'h0000, rows[i].exp});
    end
    rd = {16'h0000, mm_base, 5'h00, rt_halt_en, resp_time_sel, timetag_sync,
          watchdog_en, message_in_progress_output};
    chk(rd, 32'h0000_041f);
    // **************
    // awkward cases
    // **************
    seq_online = 1'b0;
    rdx(7'h6c);
    chk(rd, 32'h0000_0000);
    seq_online = 1'b1;
    for (i = 1; i < 3; i++) begin
      {cmp_valid, cmp_less, cmp_equal} = {1'b1, i[1:0]};
      step();
      cmp_valid = 1'b0;
      rdx(7'h6c);
      chk(rd, {16'h0000, 16'ha500 | i[15:0]});
    end
    bist_start = 1'b1;
    step();
    bist_start = 1'b0;
    rdx(7'h70);
    chk(rd, 32'h0000_0040);
    {bist_pass, bist_done} = 2'b11;
    step();
    {bist_pass, bist_done} = 2'b00;
    rdx(7'h70);
    chk(rd, 32'h0000_00a0);
    {bist_start, bist_done} = 2'b11;
    step();
    {bist_start, bist_done} = 2'b00;
    rdx(7'h70);
    chk(rd, 32'h0000_0080);
    bcf_host_i.xfer(1'b0, 32'h0000_0064, 16'h0000, 2'b11, rd, ok);
    chk({31'h0000_0000, ok}, 32'h0000_0000);
    rst_n = 1'b0;
    repeat (2) step();
    rst_n = 1'b1;
    rdx(7'h64);
    chk(rd, 32'h0000_0000);
    chk({24'h00_0000, gp_flags}, 32'h0000_0000);
    print_verdict();
  end
endmodule
`default_nettype wire

// *** verilog/bcf_flag_bank.sv ***
// eight general-purpose branch flags with host set/clear and compare update
// assumes one write pulse per host data phase, lanes already decoded
`timescale 1ns/10ps
`default_nettype none

`include "bcf_map.svh"

module bcf_flag_bank
  import bcf_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        host_wr,
  input  wire logic [15:0] host_wdata,
  input  wire logic [1:0]  host_be,
  input  wire logic        cmp_valid,
  input  wire logic        cmp_less,
  input  wire logic        cmp_equal,
  output logic      [7:0]  flags
);

  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic [7:0] next_flags;

  always_comb begin
    set_bits = (host_wr && host_be[0]) ? host_wdata[`BCF_FLAG_SET] : '0;
    clr_bits = (host_wr && host_be[1]) ? host_wdata[`BCF_FLAG_CLR] : '0;
    // set beats clear when software asks for both at once
    next_flags = (flags & ~clr_bits) | set_bits;
    // compare result owns the two shared positions in its cycle
    if (cmp_valid) begin
      next_flags[`BCF_FLAG_LESS]  = cmp_less;
      next_flags[`BCF_FLAG_EQUAL] = cmp_equal;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flags <= `BCF_FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

endmodule

`default_nettype wire

// *** verilog/bcf_map.svh ***
// register offsets, field positions, reset values and bus codes for the
// condition/flag register bank; assumes a 32-bit memory-space target
`ifndef BCF_MAP_SVH
`define BCF_MAP_SVH

// ****************************************************************
// register byte offsets inside the decoded window
// ****************************************************************
`define BCF_OFS_CONFIG_SEVEN    7'h64
`define BCF_OFS_FLAG_COND       7'h6C
`define BCF_OFS_SELF_TEST       7'h70
`define BCF_OFS_WIDTH           7
`define BCF_OFS_LO              1:0

// ****************************************************************
// configuration word layout
// ****************************************************************
`define BCF_CFG_MM_BASE         15:10
`define BCF_CFG_RT_HALT         4
`define BCF_CFG_RESP_TIME       3
`define BCF_CFG_TT_SYNC         2
`define BCF_CFG_WATCHDOG        1
`define BCF_CFG_MCR_SELECT      0
`define BCF_CFG_WMASK           16'hFC1F
`define BCF_CFG_RESET           16'h0000

// ****************************************************************
// flag port and condition word layout
// ****************************************************************
`define BCF_FLAG_SET            7:0
`define BCF_FLAG_CLR            15:8
`define BCF_COND_HI             15:8
`define BCF_COND_GP             7:2
`define BCF_FLAG_LESS           1
`define BCF_FLAG_EQUAL          0
`define BCF_FLAGS_RESET         8'h00
`define BCF_COND_OFFLINE        16'h0000

// ****************************************************************
// self-test status layout
// ****************************************************************
`define BCF_BIST_DONE           7
`define BCF_BIST_BUSY           6
`define BCF_BIST_PASS           5

// ****************************************************************
// bus command codes and widths
// ****************************************************************
`define BCF_CMD_MEM_RD          4'h6
`define BCF_CMD_MEM_WR          4'h7
`define BCF_WORD_ZERO           32'h0000_0000
`define BCF_HALF_ZERO           16'h0000

`endif

// *** verilog/bcf_pkg.sv ***
// types shared by the condition/flag register bank
// assumes bcf_map.svh supplies the numeric layout
package bcf_pkg;

  // gray sequence idle -> data -> turnaround
  typedef enum logic [1:0] {
    BCF_IDLE = 2'b00,
    BCF_DATA = 2'b01,
    BCF_TURN = 2'b11
  } bcf_state_t;

endpackage

// *** verilog/bcf_regs.sv ***
// condition/flag register bank behind a single-phase memory-space target
// assumes synchronous bus inputs and one clock; no burst, no config space
`timescale 1ns/10ps
`default_nettype none

`include "bcf_map.svh"

// Overview of operation
// - Writing a one to flag-port bit n (0..7) sets flag n.
// - Writing a one to flag-port bit 8+n clears flag n.
// - The flag port and condition word share one address, write vs read.
// - Condition bits 2..7 show flags 2..7.
// - Condition bits 1 and 0 show less-than and equal, shared with flags.
// - The condition word reads zero unless the sequencer is online.
// - Self-test word shows complete, in progress and passed in bits 7..5.
// - Config bits 15..10 hold a host read/write memory base address.
// - Config bit 1 enables the watchdog, bit 4 enables terminal halt.
// - Config bit 0 selects mode-code reset or message-in-progress output.
module bcf_regs
  import bcf_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = 32'h0000_0000
)
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  // target bus
  input  wire logic        frame_n,
  input  wire logic        irdy_n,
  input  wire logic [31:0] ad_in,
  input  wire logic [3:0]  cbe_n,
  output logic      [31:0] ad_out,
  output logic             ad_oe,
  output logic             par_out,
  output logic             par_oe,
  output logic             devsel_n,
  output logic             devsel_oe,
  output logic             trdy_n,
  output logic             trdy_oe,
  output logic             stop_n,
  output logic             stop_oe,
  // sequencer side
  input  wire logic        seq_online,
  input  wire logic [7:0]  seq_cond_hi,
  input  wire logic        cmp_valid,
  input  wire logic        cmp_less,
  input  wire logic        cmp_equal,
  output logic      [7:0]  gp_flags,
  // self-test side
  input  wire logic        bist_start,
  input  wire logic        bist_done,
  input  wire logic        bist_pass,
  // configuration outputs
  output logic      [5:0]  mm_base,
  output logic             rt_halt_en,
  output logic             resp_time_sel,
  output logic             timetag_sync,
  output logic             watchdog_en,
  output logic             message_in_progress_output
);

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic hit(input logic [31:0] a);
    hit = (a[31:`BCF_OFS_WIDTH] == BASE_ADDR[31:`BCF_OFS_WIDTH]);
  endfunction

  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic at_ofs(input logic [`BCF_OFS_WIDTH-1:0] o,
                                  input logic [`BCF_OFS_WIDTH-1:0] r);
    at_ofs = (o == r);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  bcf_state_t  state;
  logic        is_write;
  logic [`BCF_OFS_WIDTH-1:0] ofs;
  logic [15:0] config_word_seven;
  logic        bist_complete;
  logic        bist_busy;
  logic        bist_passed;
  logic        take;
  logic        claim;
  logic        host_wr;
  logic [1:0]  be;
  logic [15:0] cond_word;
  logic [15:0] rd_half;
  logic [15:0] next_config;
  logic        strobe_low;
  logic        rd_claim;
  logic        cfg_wr;
  logic        flag_wr;

  // ****************************************************************
  // address and command decode
  // ****************************************************************
  // only aligned memory commands inside the window are claimed;
  // anything else is left for another target on the bus
  assign claim = (state == BCF_IDLE) && !frame_n && hit(ad_in)
               && ad_in[`BCF_OFS_LO] == 2'b00
               && (cbe_n == ~`BCF_CMD_MEM_RD || cbe_n == ~`BCF_CMD_MEM_WR);
  assign take    = (state == BCF_DATA) && !irdy_n;
  assign host_wr = take && is_write;
  assign be      = ~cbe_n[1:0];
  // command bit 0 is low for reads, high for writes, so cbe_n[0] is high for reads
  assign rd_claim   = claim && cbe_n[0];
  // strobes stay asserted from the claim until the initiator is ready
  assign strobe_low = claim || (state == BCF_DATA && !take);
  assign cfg_wr     = host_wr && at_ofs(ofs, `BCF_OFS_CONFIG_SEVEN);
  assign flag_wr    = host_wr && at_ofs(ofs, `BCF_OFS_FLAG_COND);

  // ****************************************************************
  // bus target sequencing
  // ****************************************************************
  // single data phase: trdy and stop together force a disconnect,
  // so bursts are cut after one word rather than decoded
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state    <= BCF_IDLE;
      is_write <= 1'b0;
      ofs      <= '0;
    end else begin
      unique case (state)
        BCF_IDLE: begin
          if (claim) begin
            state    <= BCF_DATA;
            is_write <= ~cbe_n[0];
            ofs      <= ad_in[`BCF_OFS_WIDTH-1:0];
          end
        end
        BCF_DATA: begin
          if (take) begin
            state <= BCF_TURN;
          end
        end
        BCF_TURN: begin
          state <= BCF_IDLE;
        end
        // the unused code falls back to idle instead of hanging the bus
        default: begin
          state <= BCF_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      devsel_n  <= 1'b1;
      trdy_n    <= 1'b1;
      stop_n    <= 1'b1;
    end else begin
      devsel_n  <= !strobe_low;
      trdy_n    <= !strobe_low;
      stop_n    <= !strobe_low;
    end
  end

  // enables outlast the strobes by one clock, so each line is driven
  // high through the turnaround before it is let go
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      devsel_oe <= 1'b0;
      trdy_oe   <= 1'b0;
      stop_oe   <= 1'b0;
    end else begin
      devsel_oe <= claim || state == BCF_DATA;
      trdy_oe   <= claim || state == BCF_DATA;
      stop_oe   <= claim || state == BCF_DATA;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  always_comb begin
    cond_word = `BCF_COND_OFFLINE;
    if (seq_online) begin
      cond_word[`BCF_COND_HI]     = seq_cond_hi;
      cond_word[`BCF_COND_GP]     = gp_flags[`BCF_COND_GP];
      cond_word[`BCF_FLAG_LESS]   = gp_flags[`BCF_FLAG_LESS];
      cond_word[`BCF_FLAG_EQUAL]  = gp_flags[`BCF_FLAG_EQUAL];
    end
    rd_half = `BCF_HALF_ZERO;
    // in-window offsets that name no register read zero
    unique case (ad_in[`BCF_OFS_WIDTH-1:0])
      `BCF_OFS_CONFIG_SEVEN: rd_half = config_word_seven;
      `BCF_OFS_FLAG_COND:    rd_half = cond_word;
      `BCF_OFS_SELF_TEST: begin
        rd_half[`BCF_BIST_DONE] = bist_complete;
        rd_half[`BCF_BIST_BUSY] = bist_busy;
        rd_half[`BCF_BIST_PASS] = bist_passed;
      end
      default: rd_half = `BCF_HALF_ZERO;
    endcase
  end

  // read data is latched at the claim edge, so the word is a snapshot
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ad_out <= `BCF_WORD_ZERO;
      ad_oe  <= 1'b0;
    end else begin
      if (rd_claim) begin
        ad_out <= {`BCF_HALF_ZERO, rd_half};
      end
      ad_oe <= rd_claim || (state == BCF_DATA && !is_write && !take);
    end
  end

  // parity follows the data phase by one clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      par_out <= 1'b0;
      par_oe  <= 1'b0;
    end else begin
      par_out <= ^{ad_out, cbe_n};
      par_oe  <= take && !is_write;
    end
  end

  // ****************************************************************
  // configuration word
  // ****************************************************************
  always_comb begin
    next_config = config_word_seven;
    // a disabled byte lane keeps its old bits
    if (cfg_wr) begin
      next_config = (config_word_seven & ~lane_mask(be))
                  | (ad_in[15:0] & lane_mask(be));
      next_config = next_config & `BCF_CFG_WMASK;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      config_word_seven <= `BCF_CFG_RESET;
    end else begin
      config_word_seven <= next_config;
    end
  end

  // ****************************************************************
  // configuration outputs
  // ****************************************************************
  // copied from the next value so the pins never lag the register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mm_base                    <= '0;
      rt_halt_en                 <= 1'b0;
      resp_time_sel              <= 1'b0;
      timetag_sync               <= 1'b0;
      watchdog_en                <= 1'b0;
      message_in_progress_output <= 1'b0;
    end else begin
      mm_base                    <= next_config[`BCF_CFG_MM_BASE];
      rt_halt_en                 <= next_config[`BCF_CFG_RT_HALT];
      resp_time_sel              <= next_config[`BCF_CFG_RESP_TIME];
      timetag_sync               <= next_config[`BCF_CFG_TT_SYNC];
      watchdog_en                <= next_config[`BCF_CFG_WATCHDOG];
      message_in_progress_output <= next_config[`BCF_CFG_MCR_SELECT];
    end
  end

  // ****************************************************************
  // general-purpose flags
  // ****************************************************************
  // set and clear lanes are resolved inside the bank
  bcf_flag_bank u_flags (
    .clock      (clock),
    .rst_n      (rst_n),
    .host_wr    (flag_wr),
    .host_wdata (ad_in[15:0]),
    .host_be    (be),
    .cmp_valid  (cmp_valid),
    .cmp_less   (cmp_less),
    .cmp_equal  (cmp_equal),
    .flags      (gp_flags)
  );

  // ****************************************************************
  // ram self-test status
  // ****************************************************************
  // a done pulse in the start cycle is taken as the newer event
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bist_complete <= 1'b0;
      bist_busy     <= 1'b0;
      bist_passed   <= 1'b0;
    end else if (bist_done) begin
      bist_complete <= 1'b1;
      bist_busy     <= 1'b0;
      bist_passed   <= bist_pass;
    end else if (bist_start) begin
      bist_complete <= 1'b0;
      bist_busy     <= 1'b1;
      bist_passed   <= 1'b0;
    end
  end

endmodule

`default_nettype wire
